// ===== logic/arb_trig_pkg.sv
package arb_trig_pkg;
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int US_NS         = 1000;
    localparam int US_CYCLES     = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [6:0] US_LAST = 7'(US_CYCLES - 1);
    localparam int EXT_DELAY_MS  = 100;
    // sizes
    localparam int SAMPLE_W   = 32;
    localparam int FIFO_DEPTH = 4;
    localparam int MEM_WORDS  = 64;
    // byte offsets
    localparam logic [8:0] ADR_CTRL   = 9'h000;
    localparam logic [8:0] ADR_DELAY  = 9'h004;
    localparam logic [8:0] ADR_SEQ    = 9'h008;
    localparam logic [8:0] ADR_IDLE   = 9'h00C;
    localparam logic [8:0] ADR_TRIG   = 9'h010;
    localparam logic [8:0] ADR_STATUS = 9'h014;
    localparam logic [8:0] ADR_MEM    = 9'h100;
    // control fields
    localparam int CTRL_EN        = 0;
    localparam int CTRL_MODE_LSB  = 1;
    localparam int CTRL_VAR_LSB   = 3;
    localparam int CTRL_POS       = 5;
    localparam int CTRL_GATE_HIGH = 6;
    localparam int CTRL_SRC_EXT   = 7;
    localparam int CTRL_EXT_SEL   = 8;
    localparam int CTRL_DLY_EN    = 9;
    // sequence and status fields
    localparam int SEQ_LEN_LSB  = 0;
    localparam int SEQ_NSEG_LSB = 4;
    localparam int STAT_IDX_LSB = 0;
    localparam int STAT_SEG_LSB = 4;
    localparam int STAT_PEND    = 6;
    localparam int STAT_ST_LSB  = 8;
    // modes and variants
    localparam logic [1:0] MODE_CONT    = 2'h0;
    localparam logic [1:0] MODE_SINGLE  = 2'h1;
    localparam logic [1:0] MODE_SEGADV  = 2'h2;
    localparam logic [1:0] MODE_GATED   = 2'h3;
    localparam logic [1:0] VAR_NORETRIG = 2'h0;
    localparam logic [1:0] VAR_BUFFERED = 2'h1;
    localparam logic [1:0] VAR_RESTART  = 2'h2;
    localparam logic [1:0] VAR_SEG_CONT = 2'h1;
    // reset values
    localparam logic [31:0] CTRL_RST  = 32'h0000_0020;
    localparam logic [31:0] DELAY_RST = 32'(EXT_DELAY_MS * 1000);
    localparam logic [31:0] SEQ_RST   = 32'h0000_000F;
    localparam logic [31:0] IDLE_RST  = 32'h0000_0000;
    typedef enum logic [2:0] {ST_OFF, ST_WAIT, ST_DELAY, ST_PLAY, ST_RESTART} run_state_t;
endpackage

// ===== logic/sample_fifo.sv
`timescale 1ns/1ns
module sample_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             flush_i,
    // fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
    } fifo_t;

    fifo_t            q;
    fifo_t            next_q;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             pop;

    // honest flags straight from the occupancy count
    assign in_ready_o  = (q.cnt != (AW+1)'(DEPTH));
    assign out_valid_o = (q.cnt != '0);
    assign out_data_o  = mem[q.rp];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    // pointers wrap naturally; depth must be a power of two
    always_comb begin
        next_q = q;
        if (push) begin
            next_q.wp = q.wp + AW'(1);
        end
        if (pop) begin
            next_q.rp = q.rp + AW'(1);
        end
        next_q.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
        if (flush_i) begin
            next_q = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    // storage has no reset; contents are qualified by the count
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[q.wp] <= in_data_i;
        end
    end
endmodule

// ===== logic/arb_waveform_trigger_control.sv
`timescale 1ns/1ns
module arb_waveform_trigger_control
    import arb_trig_pkg::*;
(
    // clock and reset
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    // wishbone slave
    input  wire logic                cyc_i,
    input  wire logic                stb_i,
    input  wire logic                we_i,
    input  wire logic [31:0]         adr_i,
    input  wire logic [31:0]         dat_i,
    input  wire logic [3:0]          sel_i,
    output logic [31:0]              dat_o,
    output logic                     ack_o,
    // external trigger inputs, bit 0 is the pattern_trigger_input
    input  wire logic [1:0]          ext_trig_i,
    // sample stream to the modulator
    output logic [SAMPLE_W-1:0]      sample_o,
    output logic                     sample_valid_o,
    input  wire logic                sample_ready_i,
    output logic                     playing_o
);
    typedef struct packed {
        logic              ack;
        logic [31:0]       rdata;
        logic [31:0]       ctrl;
        logic [31:0]       delay;
        logic [31:0]       seq;
        logic [31:0]       idle;
        logic [1:0]        s1;
        logic [1:0]        s2;
        logic              prev;
        run_state_t        st;
        logic [1:0]        seg;
        logic [3:0]        idx;
        logic              pend;
        logic [6:0]        us_cnt;
        logic [31:0]       dly_cnt;
        logic [SAMPLE_W-1:0] out;
        logic              out_valid;
        logic              playing;
    } core_t;

    core_t               q;
    core_t               next_q;
    logic [SAMPLE_W-1:0] wave_mem [MEM_WORDS];
    logic [8:0]          adr;
    logic                hit;
    logic                wr;
    logic                rd;
    logic                mem_we;
    logic                manual;
    logic                cfg_chg;
    logic                en;
    logic [1:0]          mode;
    logic [1:0]          var_sel;
    logic [3:0]          seg_last;
    logic [1:0]          nseg_last;
    logic                lvl;
    logic                ext_edge;
    logic                gate_on;
    logic                trig;
    logic                push;
    logic                acc;
    logic                seg_end;
    logic                last_seg;
    logic                pend_eff;
    logic                flush;
    logic                us_tick;
    logic                f_in_ready;
    logic                f_out_valid;
    logic                f_out_ready;
    logic [SAMPLE_W-1:0] f_out_data;
    logic [1:0]          seg_next;

    // byte-lane merge for writes
    function automatic logic [31:0] bmask(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    // bus decode; upper address bits must be zero to hit the map
    assign adr    = {adr_i[8:2], 2'b00};
    assign hit    = (adr_i[31:9] == 23'h0);
    assign wr     = cyc_i & stb_i & we_i & ~q.ack;
    assign rd     = cyc_i & stb_i & ~we_i & ~q.ack;
    assign mem_we = wr & hit & (adr >= ADR_MEM);

    assign en        = q.ctrl[CTRL_EN];
    assign mode      = q.ctrl[CTRL_MODE_LSB +: 2];
    assign var_sel   = q.ctrl[CTRL_VAR_LSB +: 2];
    assign seg_last  = q.seq[SEQ_LEN_LSB +: 4];
    assign nseg_last = q.seq[SEQ_NSEG_LSB +: 2];

    // manual key is a write of one to the trigger register
    assign manual = wr & hit & (adr == ADR_TRIG) & sel_i[0] & dat_i[0];
    // mode, variant or sequence register change forces a fresh wait
    assign cfg_chg = wr & hit & (((adr == ADR_CTRL) & sel_i[0] &
                     (dat_i[4:1] != q.ctrl[4:1])) | (adr == ADR_SEQ));

    // edge selection only ever looks at the second stage
    assign lvl      = q.s2[q.ctrl[CTRL_EXT_SEL]];
    assign ext_edge = q.ctrl[CTRL_POS] ? (lvl & ~q.prev) : (~lvl & q.prev);
    assign gate_on  = (lvl == q.ctrl[CTRL_GATE_HIGH]);
    assign trig     = q.ctrl[CTRL_SRC_EXT] ? ext_edge : manual;

    // playback feeds the fifo, held off while the gate is shut
    assign push     = (q.st == ST_PLAY) & ((mode != MODE_GATED) | gate_on);
    assign acc      = push & f_in_ready;
    assign seg_end  = acc & (q.idx == seg_last);
    assign last_seg = (q.seg == nseg_last);
    assign seg_next = last_seg ? 2'h0 : q.seg + 2'h1;
    assign pend_eff = q.pend | trig;
    assign us_tick  = (q.us_cnt == US_LAST);
    assign f_out_ready = ~q.out_valid | sample_ready_i;

    // all next-state logic for bus, trigger and playback
    always_comb begin
        next_q     = q;
        flush      = 1'b0;
        next_q.ack = cyc_i & stb_i & ~q.ack;
        next_q.s1   = ext_trig_i;
        next_q.s2   = q.s1;
        next_q.prev = lvl;
        if (wr & hit) begin
            if (adr == ADR_CTRL) begin
                next_q.ctrl = bmask(q.ctrl, dat_i, sel_i) & 32'h0000_03FF;
            end else if (adr == ADR_DELAY) begin
                next_q.delay = bmask(q.delay, dat_i, sel_i);
            end else if (adr == ADR_SEQ) begin
                next_q.seq = bmask(q.seq, dat_i, sel_i) & 32'h0000_003F;
            end else if (adr == ADR_IDLE) begin
                next_q.idle = bmask(q.idle, dat_i, sel_i);
            end
        end
        if (rd) begin
            next_q.rdata = 32'h0;
            if (!hit) begin
                next_q.rdata = 32'h0;
            end else if (adr == ADR_CTRL) begin
                next_q.rdata = q.ctrl;
            end else if (adr == ADR_DELAY) begin
                next_q.rdata = q.delay;
            end else if (adr == ADR_SEQ) begin
                next_q.rdata = q.seq;
            end else if (adr == ADR_IDLE) begin
                next_q.rdata = q.idle;
            end else if (adr == ADR_STATUS) begin
                next_q.rdata[STAT_IDX_LSB +: 4] = q.idx;
                next_q.rdata[STAT_SEG_LSB +: 2] = q.seg;
                next_q.rdata[STAT_PEND]         = q.pend;
                next_q.rdata[STAT_ST_LSB +: 3]  = q.st;
            end else if (adr >= ADR_MEM) begin
                next_q.rdata = wave_mem[adr_i[7:2]];
            end
        end

        // early triggers during a pass
        if (q.st == ST_PLAY && trig) begin
            if (mode == MODE_SINGLE && var_sel == VAR_BUFFERED) begin
                next_q.pend = 1'b1;
            end
            // segment advance waits for the segment end
            if (mode == MODE_SEGADV) begin
                next_q.pend = 1'b1;
            end
            // no-retrigger and continuous simply drop it
        end

        case (q.st)
            ST_OFF: begin
                if (en) begin
                    next_q.st = ST_WAIT;
                end
            end
            ST_WAIT: begin
                // gated starts on the first active level
                if ((mode == MODE_GATED) ? gate_on : trig) begin
                    next_q.idx = 4'h0;
                    // external delay holds the start back
                    if (q.ctrl[CTRL_SRC_EXT] && q.ctrl[CTRL_DLY_EN] && mode != MODE_GATED) begin
                        next_q.st      = ST_DELAY;
                        next_q.dly_cnt = q.delay;
                        next_q.us_cnt  = 7'h0;
                    end else begin
                        next_q.st = ST_PLAY;
                    end
                end
            end
            ST_DELAY: begin
                // microsecond enable pulse drives the delay count
                next_q.us_cnt = us_tick ? 7'h0 : q.us_cnt + 7'h1;
                if (q.dly_cnt == 32'h0) begin
                    next_q.st = ST_PLAY;
                end else if (us_tick) begin
                    next_q.dly_cnt = q.dly_cnt - 32'h1;
                end
            end
            ST_PLAY: begin
                if (mode == MODE_SINGLE && var_sel == VAR_RESTART && trig) begin
                    // restart drops queued samples, leaving a gap
                    next_q.st = ST_RESTART;
                    flush     = 1'b1;
                end else if (acc) begin
                    next_q.idx = q.idx + 4'h1;
                end
                if (seg_end && !(mode == MODE_SINGLE && var_sel == VAR_RESTART && trig)) begin
                    next_q.idx = 4'h0;
                    case (mode)
                        MODE_SINGLE: begin
                            // one pass through the sequence, then stop unless a buffered trigger is pending
                            if (!last_seg) begin
                                next_q.seg = seg_next;
                            end else if (pend_eff && var_sel == VAR_BUFFERED) begin
                                next_q.seg  = 2'h0;
                                next_q.pend = 1'b0;
                            end else begin
                                next_q.seg  = 2'h0;
                                next_q.pend = 1'b0;
                                next_q.st   = ST_WAIT;
                            end
                        end
                        MODE_SEGADV: begin
                            // one pass per segment, looped by the continuous variant until a trigger; no repetition count
                            if (pend_eff) begin
                                // advance, wrapping after the last segment
                                next_q.seg  = seg_next;
                                next_q.pend = 1'b0;
                            end else if (var_sel == VAR_SEG_CONT) begin
                                next_q.seg = q.seg;
                            end else begin
                                // park; the next trigger plays the next one
                                next_q.seg = seg_next;
                                next_q.st  = ST_WAIT;
                            end
                        end
                        default: begin
                            // continuous and gated loop the sequence
                            next_q.seg = seg_next;
                        end
                    endcase
                end
            end
            ST_RESTART: begin
                next_q.st   = ST_PLAY;
                next_q.seg  = 2'h0;
                next_q.idx  = 4'h0;
                next_q.pend = 1'b0;
            end
            default: begin
                next_q.st = ST_OFF;
            end
        endcase

        // switching off or reconfiguring abandons the pass
        if (!en) begin
            next_q.st   = ST_OFF;
            next_q.seg  = 2'h0;
            next_q.idx  = 4'h0;
            next_q.pend = 1'b0;
            flush       = q.st != ST_OFF;
        end else if (cfg_chg) begin
            next_q.st   = ST_WAIT;
            next_q.seg  = 2'h0;
            next_q.idx  = 4'h0;
            next_q.pend = 1'b0;
            flush       = 1'b1;
        end

        // output stage; idle level fills the gaps while waiting
        if (f_out_ready) begin
            if (f_out_valid) begin
                next_q.out       = f_out_data;
                next_q.out_valid = 1'b1;
                next_q.playing   = 1'b1;
            end else if (q.st == ST_WAIT || q.st == ST_DELAY) begin
                // idle rms level keeps the carrier amplitude
                next_q.out       = q.idle;
                next_q.out_valid = 1'b1;
                next_q.playing   = 1'b0;
            end else begin
                next_q.out_valid = 1'b0;
                next_q.playing   = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q       <= '0;
            q.ctrl  <= CTRL_RST;
            q.delay <= DELAY_RST;
            q.seq   <= SEQ_RST;
            q.idle  <= IDLE_RST;
            q.st    <= ST_OFF;
        end else begin
            q <= next_q;
        end
    end

    // waveform store, written word by word over the bus
    always_ff @(posedge clk_i) begin
        if (mem_we) begin
            wave_mem[adr_i[7:2]] <= bmask(wave_mem[adr_i[7:2]], dat_i, sel_i);
        end
    end

    // four-deep decoupling between store and modulator
    sample_fifo #(
        .WIDTH (SAMPLE_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .flush_i     (flush),
        .in_valid_i  (push),
        .in_ready_o  (f_in_ready),
        .in_data_i   (wave_mem[{q.seg, q.idx}]),
        .out_valid_o (f_out_valid),
        .out_ready_i (f_out_ready),
        .out_data_o  (f_out_data)
    );

    assign dat_o          = q.rdata;
    assign ack_o          = q.ack;
    assign sample_o       = q.out;
    assign sample_valid_o = q.out_valid;
    assign playing_o      = q.playing;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_CONT_KEEPS: assert property (
        (q.st == ST_PLAY && mode == MODE_CONT && en && !cfg_chg) |=> q.st == ST_PLAY)
        else $error("continuous playback stopped");
    AST_NORETRIG_DROP: assert property (
        (q.st == ST_PLAY && mode == MODE_SINGLE && var_sel == VAR_NORETRIG && trig
         && en && !cfg_chg && !seg_end) |=> (q.st == ST_PLAY && !q.pend))
        else $error("early trigger disturbed no-retrigger pass");
    AST_BUFFERED_HOLD: assert property (
        (q.st == ST_PLAY && mode == MODE_SINGLE && var_sel == VAR_BUFFERED && trig
         && en && !cfg_chg && !seg_end) |=> q.pend)
        else $error("buffered trigger lost");
    AST_RESTART_GAP: assert property (
        (q.st == ST_PLAY && mode == MODE_SINGLE && var_sel == VAR_RESTART && trig
         && en && !cfg_chg) |=> q.st == ST_RESTART ##1 (q.seg == 2'h0 && q.idx == 4'h0))
        else $error("restart did not reset playback");
    AST_SEGADV_NEEDS_TRIG: assert property (
        (q.st == ST_WAIT && mode == MODE_SEGADV && !trig && en && !cfg_chg)
        |=> q.st == ST_WAIT)
        else $error("segment started without trigger");
    AST_SEGADV_WRAP: assert property (
        (q.st == ST_PLAY && mode == MODE_SEGADV && seg_end && last_seg && pend_eff
         && en && !cfg_chg) |=> q.seg == 2'h0)
        else $error("last segment did not wrap");
    AST_GATE_PAUSE: assert property (
        (q.st == ST_PLAY && mode == MODE_GATED && !gate_on && en && !cfg_chg)
        |=> $stable(q.idx) && $stable(q.seg))
        else $error("gated playback ran while gate shut");
    AST_DELAY_WAITS: assert property (
        (q.st == ST_DELAY && q.dly_cnt != 32'h0 && en && !cfg_chg) |=> q.st == ST_DELAY)
        else $error("delay ended early");
    AST_IDLE_LEVEL: assert property (
        (q.st == ST_WAIT && f_out_ready && !f_out_valid) |=>
        (sample_valid_o && sample_o == $past(q.idle) && !playing_o))
        else $error("idle level not presented");

    COV_RESTART: cover property (q.st == ST_PLAY ##1 q.st == ST_RESTART);
    COV_WRAP: cover property (mode == MODE_SEGADV && seg_end && last_seg && pend_eff);
    COV_GATE: cover property (q.st == ST_PLAY && mode == MODE_GATED && !gate_on);
    COV_DELAY: cover property (q.st == ST_DELAY ##1 q.st == ST_PLAY);
endmodule

// ===== dv/ext_trig_src.sv
`timescale 1ns/1ns
module ext_trig_src (
    // clock
    input  wire logic       clk_i,
    // trigger or gate lines
    output logic [1:0]      ext_trig_o
);
    initial ext_trig_o = 2'h0;
    // levels move just after an edge, never mid-cycle
    task automatic set_level(input logic [1:0] v);
        @(posedge clk_i);
        ext_trig_o <= v;
    endtask
endmodule

// ===== dv/arb_waveform_trigger_control_test.sv
`timescale 1ns/1ns
module arb_waveform_trigger_control_test;
    import arb_trig_pkg::*;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, rdy = 1'b1;
    logic [31:0] adr = 32'h0, wdat = 32'h0, dat_o, q;
    logic [3:0]  sel = 4'h0;
    logic [1:0]  ext;
    logic [31:0] sample_o;
    logic        ack_o, sample_valid_o, playing_o;
    int          miscompares = 0, checks = 0, cycles = 0;
    ext_trig_src src (.clk_i(clk_i), .ext_trig_o(ext));
    arb_waveform_trigger_control dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .dat_i(wdat), .sel_i(sel), .dat_o(dat_o), .ack_o(ack_o),
        .ext_trig_i(ext), .sample_o(sample_o), .sample_valid_o(sample_valid_o),
        .sample_ready_i(rdy), .playing_o(playing_o));
    // clock and hang guard
    initial forever #5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // one classic cycle, held until ack is seen
    task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        sel  <= 4'hF;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    task automatic state_is(input int n, input logic [2:0] st);
        repeat (n) @(posedge clk_i);
        wb(1'b0, 32'(ADR_STATUS), 32'h0);
        chk({29'h0, q[10:8]}, {29'h0, st}, "player state");
    endtask
    task automatic t_regs();
        wb(1'b0, 32'(ADR_CTRL), 32'h0);
        chk(q, CTRL_RST, "ctrl reset");
        wb(1'b0, 32'(ADR_SEQ), 32'h0);
        chk(q, SEQ_RST, "seq reset");
        wb(1'b0, 32'h0000_0200, 32'h0);
        chk(q, 32'h0, "unmapped read");
    endtask
    // waveform words: segment s sample n holds C000_0000 plus 16s+n
    task automatic t_mem();
        for (int i = 0; i < 32; i++) begin
            wb(1'b1, 32'(ADR_MEM) + 32'(i * 4), 32'hC000_0000 + 32'(i));
        end
        wb(1'b0, 32'(ADR_MEM) + 32'h0000_0014, 32'h0);
        chk(q, 32'hC000_0005, "waveform word");
    endtask
    // single variants: two close triggers, second one lands mid pass
    task automatic t_single(input logic [31:0] ctrl, input logic [2:0] mid);
        wb(1'b1, 32'(ADR_IDLE), 32'h0000_1234);
        wb(1'b1, 32'(ADR_CTRL), ctrl);
        repeat (4) @(posedge clk_i);
        chk(sample_o, 32'h0000_1234, "idle level");
        chk({31'h0, sample_valid_o}, 32'h1, "idle level not valid");
        chk({31'h0, playing_o}, 32'h0, "not playing");
        wb(1'b1, 32'(ADR_TRIG), 32'h1);
        wb(1'b1, 32'(ADR_TRIG), 32'h1);
        state_is(20, mid);
        state_is(80, 3'h1);
    endtask
    // segment advance over two sixteen-sample segments
    task automatic t_seg();
        wb(1'b1, 32'(ADR_SEQ), 32'h0000_001F);
        wb(1'b1, 32'(ADR_CTRL), 32'h0000_0025);
        wb(1'b1, 32'(ADR_TRIG), 32'h1);
        do @(posedge clk_i); while (playing_o !== 1'b1);
        chk(sample_o, 32'hC000_0000, "first sample");
        @(posedge clk_i);
        chk(sample_o, 32'hC000_0001, "second sample");
        state_is(30, 3'h1);
        chk({30'h0, q[5:4]}, 32'h1, "parked segment");
        wb(1'b1, 32'(ADR_TRIG), 32'h1);
        wb(1'b1, 32'(ADR_TRIG), 32'h1);
        state_is(5, 3'h3);
        chk({30'h0, q[5:4]}, 32'h1, "segment cut short");
        state_is(10, 3'h3);
        chk({30'h0, q[5:4]}, 32'h0, "no wrap to first segment");
        wb(1'b1, 32'(ADR_CTRL), 32'h0000_002D);
        wb(1'b1, 32'(ADR_TRIG), 32'h1);
        state_is(40, 3'h3);
        chk({30'h0, q[5:4]}, 32'h0, "continuous segment moved");
        wb(1'b1, 32'(ADR_TRIG), 32'h1);
        state_is(20, 3'h3);
        chk({30'h0, q[5:4]}, 32'h1, "segment did not advance");
    endtask
    // restart variant: a mid-pass trigger starts the sequence over
    task automatic t_restart();
        wb(1'b1, 32'(ADR_CTRL), 32'h0000_0033);
        wb(1'b1, 32'(ADR_TRIG), 32'h1);
        wb(1'b1, 32'(ADR_TRIG), 32'h1);
        state_is(28, 3'h3);
        state_is(40, 3'h1);
    endtask
    task automatic t_ext();
        wb(1'b1, 32'(ADR_CTRL), 32'h0000_00A1);
        src.set_level(2'h1);
        state_is(6, 3'h3);
        state_is(100, 3'h3);
        wb(1'b1, 32'(ADR_CTRL), 32'h0000_0080);
        wb(1'b1, 32'(ADR_CTRL), 32'h0000_0081);
        state_is(4, 3'h1);
        src.set_level(2'h0);
        state_is(6, 3'h3);
        // gate shut before gated mode, so the start waits for it
        src.set_level(2'h1);
        state_is(4, 3'h3);
        wb(1'b1, 32'(ADR_CTRL), 32'h0000_0007);
        state_is(6, 3'h1);
        src.set_level(2'h0);
        state_is(6, 3'h3);
        // active-high gate: a low input keeps the player waiting
        wb(1'b1, 32'(ADR_CTRL), 32'h0000_0046);
        wb(1'b1, 32'(ADR_CTRL), 32'h0000_0047);
        state_is(4, 3'h1);
        src.set_level(2'h1);
        state_is(6, 3'h3);
        src.set_level(2'h0);
        state_is(6, 3'h3);
        chk({31'h0, playing_o}, 32'h0, "gate shut but playing");
        // delayed external start, two microseconds
        wb(1'b1, 32'(ADR_DELAY), 32'h0000_0002);
        wb(1'b1, 32'(ADR_CTRL), 32'h0000_02A3);
        src.set_level(2'h1);
        state_is(100, 3'h2);
        state_is(110, 3'h3);
    endtask
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_mem();
        t_single(32'h0000_0023, 3'h1);
        t_single(32'h0000_002B, 3'h3);
        t_seg();
        t_restart();
        t_ext();
        end_of_test();
    end
endmodule
